/* File: rtl/cpu_wait_state_control.sv */
// Wait-state control of an 8-bit processor with a two-phase clock.
// Assumes the execution core offers one bus cycle per phase pair and
// advances only when advance_o pulses; the wait-request pin is async.
`timescale 1ns/1ps
`default_nettype none
module cpu_wait_state_control
   import wait_pkg::*;
#(
   parameter int unsigned HIGH_CYC = PHASE_HIGH_CYC,
   parameter int unsigned GAP_CYC  = PHASE_GAP_CYC
) (
   input  wire logic              clk_i,
   input  wire logic              nrst_i,
   input  wire logic              ready_n_pin_i,
   input  wire bus_cycle_s        core_cycle_i,
   output logic                   phi1_o,
   output logic                   phi2_o,
   output logic [ADDR_W-1:0]      addr_o,
   output logic [DATA_W-1:0]      data_o,
   output logic                   data_oe_n_o,
   output logic                   rw_o,
   output logic                   stalled_o,
   output logic                   advance_o
);

   // ***************************************************************
   // Input synchroniser
   // ***************************************************************
   logic rdy_level;

   wait_sync u_sync (
      .clk_i   (clk_i),
      .nrst_i  (nrst_i),
      .async_i (ready_n_pin_i),
      .level_o (rdy_level)
   );

   // ***************************************************************
   // Phase decode
   // ***************************************************************
   // The same phase tests drive the pins, the wait sampling and the
   // data enable. They live in one place so that the three can never
   // disagree about where a phase starts or ends.
   function automatic logic in_phase_one(input phase_e ph);
      return ph == PH_ONE;
   endfunction

   function automatic logic in_phase_two(input phase_e ph);
      return ph == PH_TWO;
   endfunction

   // ***************************************************************
   // Phase generator
   // ***************************************************************
   phase_e                 ph_reg;
   phase_e                 ph_next;
   logic [PHASE_CNT_W-1:0] pcnt_reg;
   logic [PHASE_CNT_W-1:0] pcnt_next;
   logic                   end_of_phase;

   // Free-running phases; nothing here looks at the wait line, so a
   // slow device can never widen a phase.
   always_comb begin
      end_of_phase = (pcnt_reg == PHASE_CNT_ONE);
      pcnt_next    = pcnt_reg - PHASE_CNT_ONE;
      ph_next      = ph_reg;
      if (end_of_phase) begin
         case (ph_reg)
            PH_ONE: begin
               ph_next   = PH_GAP1;
               pcnt_next = PHASE_CNT_W'(GAP_CYC);
            end
            PH_GAP1: begin
               ph_next   = PH_TWO;
               pcnt_next = PHASE_CNT_W'(HIGH_CYC);
            end
            PH_TWO: begin
               ph_next   = PH_GAP2;
               pcnt_next = PHASE_CNT_W'(GAP_CYC);
            end
            default: begin
               ph_next   = PH_ONE;
               pcnt_next = PHASE_CNT_W'(HIGH_CYC);
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ph_reg   <= PH_GAP2;
         pcnt_reg <= PHASE_CNT_ONE;
      end else begin
         ph_reg   <= ph_next;
         pcnt_reg <= pcnt_next;
      end
   end

   // ***************************************************************
   // Wait request tracking
   // ***************************************************************
   logic rdy_prev_reg;
   logic pend_reg;
   logic pend_next;
   logic wait_reg;
   logic wait_next;
   logic fall_in_phi1;
   logic cycle_end;
   logic cur_write;

   // A cycle ends at the close of phase two; the decision for the next
   // cycle is made there.
   always_comb begin
      cycle_end    = end_of_phase && in_phase_two(ph_reg);
      cur_write    = rw_o == 1'b0;
      fall_in_phi1 = rdy_prev_reg && !rdy_level && in_phase_one(ph_reg);
      pend_next    = pend_reg;
      wait_next    = wait_reg;
      // A fall is remembered until a non-write cycle ends, so one that
      // lands in a write is not lost but deferred.
      if (fall_in_phi1) begin
         pend_next = 1'b1;
      end
      // Write cycles are never turned into waits: the pending request rides
      // along until a read ends, so a store is never issued twice.
      if (cycle_end) begin
         if (wait_reg) begin
            // Release only on a high level seen during phase two.
            if (rdy_level) begin
               wait_next = 1'b0;
            end
         end else if (pend_reg || fall_in_phi1) begin
            if (!cur_write) begin
               wait_next = 1'b1;
               pend_next = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rdy_prev_reg <= 1'b1;
         pend_reg     <= 1'b0;
         wait_reg     <= 1'b0;
      end else begin
         rdy_prev_reg <= rdy_level;
         pend_reg     <= pend_next;
         wait_reg     <= wait_next;
      end
   end

   // ***************************************************************
   // Bus drivers
   // ***************************************************************
   logic [ADDR_W-1:0] addr_next;
   logic [DATA_W-1:0] data_next;
   logic              rw_next;
   logic              oe_n_next;
   logic              adv_next;
   logic              phi1_next;
   logic              phi2_next;
   logic              stall_next;

   // New cycle loaded only when not waiting; a wait repeats the held read
   // with address and rw held and data_oe_n_o high, and no acknowledge is produced.
   always_comb begin
      addr_next = addr_o;
      data_next = data_o;
      rw_next   = rw_o;
      adv_next  = 1'b0;
      if (cycle_end && !wait_next) begin
         addr_next = core_cycle_i.addr;
         data_next = core_cycle_i.wdata;
         rw_next   = !core_cycle_i.write;
         adv_next  = 1'b1;
      end
      oe_n_next = !(in_phase_two(ph_next) && !rw_next);
      // Pins follow the phase about to be entered, so after the register
      // stage they line up with the internal sequencer.
      phi1_next  = in_phase_one(ph_next);
      phi2_next  = in_phase_two(ph_next);
      // Status only; the requester cannot rely on it as a handshake.
      stall_next = wait_next;
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         addr_o      <= ADDR_RESET;
         data_o      <= DATA_RESET;
         rw_o        <= 1'b1;
         data_oe_n_o <= 1'b1;
         advance_o   <= 1'b0;
         phi1_o      <= 1'b0;
         phi2_o      <= 1'b0;
         stalled_o   <= 1'b0;
      end else begin
         addr_o      <= addr_next;
         data_o      <= data_next;
         rw_o        <= rw_next;
         data_oe_n_o <= oe_n_next;
         advance_o   <= adv_next;
         phi1_o      <= phi1_next;
         phi2_o      <= phi2_next;
         stalled_o   <= stall_next;
      end
   end

endmodule // cpu_wait_state_control
`default_nettype wire

/* File: rtl/wait_sync.sv */
// Three-stage synchroniser with agreement filter for the wait-request pin.
// Assumes the pin is asynchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module wait_sync (
   input  wire logic clk_i,
   input  wire logic nrst_i,
   input  wire logic async_i,
   output logic      level_o
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   logic level_reg;
   logic level_next;

   // Filtered level changes only once stages two and three agree.
   always_comb begin
      level_next = (s2_reg == s3_reg) ? s2_reg : level_reg;
   end

   // The pin idles high, so every stage resets high.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s1_reg    <= 1'b1;
         s2_reg    <= 1'b1;
         s3_reg    <= 1'b1;
         level_reg <= 1'b1;
      end else begin
         s1_reg    <= async_i;
         s2_reg    <= s1_reg;
         s3_reg    <= s2_reg;
         level_reg <= level_next;
      end
   end

   assign level_o = level_reg;
endmodule // wait_sync
`default_nettype wire

/* File: shared/wait_pkg.sv */
// Package for the processor wait-state control block.
// Assumes a single 100 MHz system clock; the two processor phases are
// derived inside the block from that clock.
package wait_pkg;

   // ***************************************************************
   // Phase generation
   // ***************************************************************
   localparam int unsigned CLK_PERIOD_NS   = 10;
   // Length of each non-overlapping phase high pulse, in ns.
   localparam int unsigned PHASE_HIGH_NS   = 40;
   // Gap between phases, in ns, keeping the phases non-overlapping.
   localparam int unsigned PHASE_GAP_NS    = 10;
   localparam int unsigned PHASE_HIGH_CYC  =
      (PHASE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned PHASE_GAP_CYC   =
      (PHASE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned PHASE_CNT_W     = 4;
   localparam logic [PHASE_CNT_W-1:0] PHASE_CNT_ZERO = 4'h0;
   localparam logic [PHASE_CNT_W-1:0] PHASE_CNT_ONE  = 4'h1;

   // Bus widths of the machine.
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned DATA_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
   localparam logic [ADDR_W-1:0] ADDR_STEP  = 16'h0001;
   localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

   // Phase sequencer, Gray coded along its loop.
   typedef enum logic [1:0] {
      PH_ONE  = 2'b00,
      PH_GAP1 = 2'b01,
      PH_TWO  = 2'b11,
      PH_GAP2 = 2'b10
   } phase_e;

   // Bus cycle as presented by the execution core.
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              write;
   } bus_cycle_s;

endpackage : wait_pkg

/* File: testbench/tb.sv */
// Self-checking bench for the wait-state block.
// Assumes default phase lengths, ten clocks to a machine cycle.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import wait_pkg::*;
   logic              clk_i = 1'b0;
   logic              nrst_i = 1'b0;
   logic              pin, phi1, phi2, oe_n, rw, stalled, adv;
   logic              p1_d = 1'b0;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] data;
   bus_cycle_s        core = '{addr: 16'h1234, wdata: 8'h5a, write: 1'b0};
   int                mismatches = 0, n_checks = 0, waits = 0, oe_lo = 0, cycles = 0;
   always #5 clk_i = ~clk_i;
   cpu_wait_state_control dut (.clk_i, .nrst_i, .ready_n_pin_i(pin), .core_cycle_i(core),
      .phi1_o(phi1), .phi2_o(phi2), .addr_o(addr), .data_o(data), .data_oe_n_o(oe_n),
      .rw_o(rw), .stalled_o(stalled), .advance_o(adv));
   wait_requester req (.clk_i, .phi2_i(phi2), .ready_n_o(pin));
   // ****
   // Monitor and timeout
   // ****
   // Sampled on falling edges so the block's own updates have landed.
   always @(negedge clk_i) begin
      p1_d <= phi1;
      if (phi1 && !p1_d && stalled) waits++;
      if (!oe_n) oe_lo++;
      cycles++;
      if (cycles > 2000) begin
         mismatches++;
         print_verdict();
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks=%0d mismatches=%0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // ****
   // Scenarios
   // ****
   task automatic reset_values();
      check({phi1, phi2, oe_n, rw, stalled, adv}, 6'h0c);
      check(addr, 16'h0000);
   endtask
   // A wait of n cycles; the core moves on while stalled and must not leak through.
   task automatic read_stall(input int n);
      core.write = 1'b0;
      core.addr = 16'h1234;
      repeat (30) @(negedge clk_i);
      waits = 0;
      req.stall(n);
      core.addr = 16'hbeef;
      check(stalled, 1'b1);
      check(addr, 16'h1234);
      repeat (30) @(negedge clk_i);
      check(waits, n);
      check(addr, 16'hbeef);
   endtask
   // A request during writes is remembered and served after the next read.
   task automatic write_defer();
      core.write = 1'b1;
      core.wdata = 8'ha5;
      repeat (30) @(negedge clk_i);
      oe_lo = 0;
      req.stall(0);
      repeat (30) @(negedge clk_i);
      check(stalled, 1'b0);
      check(rw, 1'b0);
      check(data, 8'ha5);
      check(oe_lo != 0, 1'b1);
      waits = 0;
      core.write = 1'b0;
      repeat (40) @(negedge clk_i);
      check(waits, 1);
   endtask
   initial begin
      repeat (10) @(negedge clk_i);
      reset_values();
      nrst_i = 1'b1;
      read_stall(1);
      read_stall(3);
      write_defer();
      print_verdict();
   end
endmodule // tb
`default_nettype wire

/* File: testbench/wait_asserts.sv */
// Checker for the wait-state block, watching only its ports.
// Assumes it is bound to every instance by the statement at the foot.
`timescale 1ns/1ps
`default_nettype none
module wait_asserts #(
   parameter int unsigned HIGH_CYC = 4,
   parameter int unsigned GAP_CYC  = 1
) (
   input wire logic        clk_i,
   input wire logic        nrst_i,
   input wire logic        phi1_o,
   input wire logic        phi2_o,
   input wire logic [15:0] addr_o,
   input wire logic        data_oe_n_o,
   input wire logic        rw_o,
   input wire logic        stalled_o,
   input wire logic        advance_o
);
   // ****
   // Phase and stall relations
   // ****
   localparam int unsigned CYC = 2 * (HIGH_CYC + GAP_CYC);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   // Phases keep their length even while stalled, since slow devices get wait cycles.
   phase_len_a: assert property ($rose(phi1_o) |-> ##HIGH_CYC $fell(phi1_o))
      else $error("phase one length wrong");
   cycle_len_a: assert property ($rose(phi1_o) |-> ##CYC $rose(phi1_o))
      else $error("machine cycle stretched");
   no_overlap_a: assert property (!(phi1_o && phi2_o))
      else $error("phases overlap");
   addr_hold_a: assert property (stalled_o |-> $stable(addr_o))
      else $error("address moved in a wait");
   wait_noadv_a: assert property (stalled_o |-> !advance_o)
      else $error("advance during a wait");
   read_stall_a: assert property (stalled_o |-> rw_o)
      else $error("wait on a write cycle");
   adv_once_a: assert property (advance_o |=> !advance_o [*8])
      else $error("advance too often");
   stall_edge_a: assert property ($changed(stalled_o) |-> ##[0:3] $rose(phi1_o))
      else $error("wait off the cycle boundary");
   drive_write_a: assert property (!data_oe_n_o |-> !rw_o)
      else $error("data driven on a read");
endmodule // wait_asserts
bind cpu_wait_state_control wait_asserts #(.HIGH_CYC(HIGH_CYC), .GAP_CYC(GAP_CYC)) chk (
   .clk_i, .nrst_i, .phi1_o, .phi2_o, .addr_o, .data_oe_n_o, .rw_o, .stalled_o, .advance_o);
`default_nettype wire

/* File: testbench/wait_requester.sv */
// Model of the outside logic that asks the processor for wait cycles.
// Assumes phi2_i comes from the block; the request line idles high.
`timescale 1ns/1ps
`default_nettype none
module wait_requester (
   input  wire logic clk_i,
   input  wire logic phi2_i,
   output logic      ready_n_o
);
   // ****
   // Request sequence
   // ****
   initial ready_n_o = 1'b1;
   // Falls late in phase two so that, after the block's synchroniser, it lands in phase one.
   task automatic stall(input int n);
      @(posedge phi2_i);
      repeat (3) @(negedge clk_i);
      ready_n_o = 1'b0;
      repeat (n + 1) @(negedge phi2_i);
      @(negedge clk_i);
      ready_n_o = 1'b1;
   endtask
endmodule // wait_requester
`default_nettype wire
